// File: core/hostport_pkg.sv
// Shared constants and types of the host bus port.
package hostport_pkg;
    localparam int ADDR_W     = 7;
    localparam int DATA_W     = 16;
    localparam int FIFO_DEPTH = 64;
    localparam int LEVEL_W    = 7;
    localparam int CHANNELS   = 2;

    localparam logic [6:0] FIFO_FULL  = 7'h40;
    localparam logic [6:0] LEVEL_ZERO = 7'h00;

    // Address map: bit 6 picks the channel, bit 5 low is the FIFO window.
    localparam int CH_SEL_BIT   = 6;
    localparam int FIFO_WIN_BIT = 5;
    localparam logic [5:0] STATUS_OFF = 6'h20;
    localparam logic [5:0] CMD_OFF    = 6'h21;
    localparam int CMD_FLUSH_RX_BIT   = 0;
    localparam int CMD_FLUSH_TX_BIT   = 1;

    // DMA request bit of channel c is c*2 plus this index.
    localparam int DMA_TX_IDX = 0;
    localparam int DMA_RX_IDX = 1;

    localparam logic [7:0]  BYTE_RESET = 8'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [1:0]  WARM_DONE  = 2'h3;

    typedef enum {
        BUS_RW_STROBE,
        BUS_DATA_STROBE,
        BUS_MUXED
    } bus_mode_t;

    typedef struct packed {
        logic [6:0]  addr;
        logic [15:0] data;
        logic        ale;
        logic        read_or_data_strobe_n;
        logic        wr_rw_n;
        logic        cs_n;
        logic        width;
        logic        lane_n;
        logic [1:0]  dack_n;
    } pins_t;

    localparam pins_t PINS_IDLE = '{addr: 7'h00, data: 16'h0000, ale: 1'b0, read_or_data_strobe_n: 1'b1,
                                    wr_rw_n: 1'b1, cs_n: 1'b1, width: 1'b0, lane_n: 1'b1,
                                    dack_n: 2'h3};
endpackage : hostport_pkg

// File: core/pair_buffer.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module pair_buffer #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    // Filling side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Draining side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    logic [WIDTH-1:0] mem_q [2];
    logic             wp_q, wp_d, rp_q, rp_d;
    logic [1:0]       cnt_q, cnt_d;
    logic             push, pop;

    assign in_ready_o  = (cnt_q != 2'h2);
    assign out_valid_o = (cnt_q != 2'h0);
    assign out_data_o  = mem_q[rp_q];

    always_comb begin
        push  = in_valid_i & in_ready_o;
        pop   = out_valid_o & out_ready_i;
        wp_d  = wp_q ^ push;
        rp_d  = rp_q ^ pop;
        cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wp_q     <= 1'b0;
            rp_q     <= 1'b0;
            cnt_q    <= 2'h0;
            mem_q[0] <= '0;
            mem_q[1] <= '0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
            if (push) begin
                mem_q[wp_q] <= in_data_i;
            end
        end
    end
endmodule : pair_buffer
`default_nettype wire

// File: core/byte_fifo.sv
// Byte FIFO that moves one or two bytes per side and cycle.
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
    parameter int DEPTH = 64,
    parameter int LVL_W = 7
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    input  wire logic             flush_i,
    // Write side, first byte in the low half
    input  wire logic             push_i,
    input  wire logic             push_two_i,
    input  wire logic [15:0]      wdata_i,
    // Read side, head byte in the low half
    input  wire logic             pop_i,
    input  wire logic             pop_two_i,
    output logic      [15:0]      rdata_o,
    output logic      [LVL_W-1:0] level_o
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [7:0]       mem_q [DEPTH];
    logic [PTR_W-1:0] wp_q, wp_d, rp_q, rp_d, wp1, rp1;
    logic [LVL_W-1:0] lvl_q, lvl_d, n_in, n_out;

    assign level_o = lvl_q;
    assign rp1     = rp_q + PTR_W'(1);
    assign wp1     = wp_q + PTR_W'(1);
    assign rdata_o = {mem_q[rp1], mem_q[rp_q]};

    // The caller checks room and fill before asking, so the level never wraps.
    always_comb begin
        n_in  = push_i ? (push_two_i ? LVL_W'(2) : LVL_W'(1)) : LVL_W'(0);
        n_out = pop_i ? (pop_two_i ? LVL_W'(2) : LVL_W'(1)) : LVL_W'(0);
        wp_d  = flush_i ? rp_q : wp_q + PTR_W'(n_in);
        rp_d  = rp_q + PTR_W'(n_out);
        lvl_d = flush_i ? '0 : lvl_q + n_in - n_out;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wp_q  <= '0;
            rp_q  <= '0;
            lvl_q <= '0;
        end else begin
            wp_q  <= flush_i ? rp_d : wp_d;
            rp_q  <= rp_d;
            lvl_q <= lvl_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (push_i && !flush_i) begin
            mem_q[wp_q] <= wdata_i[7:0];
            if (push_two_i) begin
                mem_q[wp1] <= wdata_i[15:8];
            end
        end
    end
endmodule : byte_fifo
`default_nettype wire

// File: core/host_port.sv
// Host bus port of a dual-channel serial controller with FIFOs and DMA requests.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [RULE1] Seven-bit address selects one internal register
// [RULE2] Narrow mode: upper data byte never driven
// [RULE3] Wide mode drives and accepts sixteen lines
// [RULE4] Byte lane from A0, lane select, style
// [RULE5] Address-latch level or toggling picks bus style
// [RULE6] Multiplexed style latches address on latch fall
// [RULE7] Host ties address pins to low data lines
// [RULE8] Per channel registers, 64-byte FIFO each way
// [RULE9] Four DMA requests, one per FIFO
// [RULE10] DMA read pops receive FIFO, ignores address
// [RULE11] DMA write pushes transmit FIFO, ignores address
// [RULE12] Select needed, except during DMA cycles
module host_port
    import hostport_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    arst_n_i,
    // Host bus pins
    input  wire logic [6:0]              addr_i,
    input  wire logic                    ale_i,
    input  wire logic                    read_or_data_strobe_n_i,
    input  wire logic                    write_or_rw_n_i,
    input  wire logic                    cs_n_i,
    input  wire logic                    width_i,
    input  wire logic                    byte_lane_select_n_i,
    input  wire logic                    dma_ack_channel_one_n_i,
    input  wire logic                    dma_ack_channel_two_n_i,
    input  wire logic [15:0]             data_i,
    output logic      [15:0]             data_o,
    output logic      [15:0]             data_oe_o,
    output logic      [3:0]              dma_req_o,
    // Serial side, receive bytes in
    input  wire logic [1:0]              rx_valid_i,
    input  wire logic [1:0][7:0]         rx_data_i,
    output logic      [1:0]              rx_ready_o,
    // Serial side, transmit bytes out
    output logic      [1:0]              tx_valid_o,
    output logic      [1:0][7:0]         tx_data_o,
    input  wire logic [1:0]              tx_ready_i
);
    import hostport_pkg::*;

    pins_t            raw, s1_q, s2_q, p_q, acc;
    bus_mode_t        mode_q, mode_d;
    logic [1:0]       warm_q, warm_d;
    logic             rose_q, rose_d;
    logic [6:0]       lat_q, lat_d;
    logic [15:0]      dout_q, dout_d;
    logic [1:0]       oe_q, oe_d;
    logic             wide_q, rd_done_q, rd_done_d;
    logic [7:0]       regs_q [128];
    logic             moto, ale_fall, rd_on, wr_on_s, wr_on_p, wr_go, rd_go, is_dma;
    logic [6:0]       a;
    logic             ch, fifo_hit, ok, even_hi, wide;
    logic [1:0]       lanes, nb, reg_we;
    logic [6:0]       lane_addr [2];
    logic [7:0]       lane_val [2];
    logic [15:0]      rd_val;
    logic [6:0]       rx_level [2];
    logic [6:0]       tx_level [2];
    logic [15:0]      rx_head [2];
    logic [1:0]       rx_pop, tx_push, flush_rx, flush_tx, txb_valid, txb_ready;
    logic             two;
    logic [15:0]      tx_wdata;

    // Every pin passes two flip-flops; p_q keeps the cycle before for edges.
    always_comb begin
        raw         = PINS_IDLE;
        raw.addr    = addr_i;
        raw.data    = data_i;
        raw.ale     = ale_i;
        raw.read_or_data_strobe_n = read_or_data_strobe_n_i;
        raw.wr_rw_n = write_or_rw_n_i;
        raw.cs_n    = cs_n_i;
        raw.width   = width_i;
        raw.lane_n  = byte_lane_select_n_i;
        raw.dack_n  = {dma_ack_channel_two_n_i, dma_ack_channel_one_n_i};
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s1_q <= PINS_IDLE;
            s2_q <= PINS_IDLE;
            p_q  <= PINS_IDLE;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            p_q  <= s2_q;
        end
    end

    function automatic logic strobe_on(pins_t x, logic m, logic wr);
        logic sel;
        sel = !x.cs_n || (x.dack_n != 2'h3); // [RULE12]
        if (m) begin
            return sel && !x.read_or_data_strobe_n && (x.wr_rw_n == !wr);
        end
        return sel && (wr ? !x.wr_rw_n : !x.read_or_data_strobe_n);
    endfunction : strobe_on

    // Edges count only once both synchroniser stages and p_q hold real pin values.
    // A full latch pulse is needed before the multiplexed style is taken, so
    // a latch pin strapped high is not mistaken for a toggling one.
    always_comb begin
        ale_fall = (warm_q == WARM_DONE) && p_q.ale && !s2_q.ale;
        warm_d   = (warm_q == WARM_DONE) ? warm_q : warm_q + 2'h1;
        rose_d   = rose_q | ((warm_q == WARM_DONE) && !p_q.ale && s2_q.ale);
        lat_d    = lat_q;
        mode_d   = mode_q;
        case (mode_q)
            BUS_RW_STROBE,
            BUS_DATA_STROBE: begin
                if (ale_fall && rose_q) begin
                    mode_d = BUS_MUXED; // [RULE5]
                end else begin
                    mode_d = s2_q.ale ? BUS_DATA_STROBE : BUS_RW_STROBE; // [RULE5]
                end
            end
            BUS_MUXED: begin
                if (ale_fall) begin
                    lat_d = p_q.addr; // [RULE6]
                end
            end
            default: mode_d = BUS_RW_STROBE;
        endcase
        if (ale_fall && rose_q && mode_q != BUS_MUXED) begin
            lat_d = p_q.addr; // [RULE6]
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_q <= BUS_RW_STROBE;
            warm_q <= 2'h0;
            rose_q <= 1'b0;
            lat_q  <= 7'h00;
        end else begin
            mode_q <= mode_d;
            warm_q <= warm_d;
            rose_q <= rose_d;
            lat_q  <= lat_d;
        end
    end

    // A write acts when its strobe ends, on the data seen one cycle before.
    // A read that meets a write end waits one cycle so the write is kept.
    always_comb begin
        moto      = (mode_q == BUS_DATA_STROBE);
        rd_on     = strobe_on(s2_q, moto, 1'b0);
        wr_on_s   = strobe_on(s2_q, moto, 1'b1);
        wr_on_p   = strobe_on(p_q, moto, 1'b1);
        wr_go     = wr_on_p && !wr_on_s;
        rd_go     = rd_on && !rd_done_q && !wr_go;
        rd_done_d = rd_on && (rd_done_q || rd_go);
        acc       = wr_go ? p_q : s2_q;
        is_dma    = (acc.dack_n != 2'h3);
        if (is_dma) begin
            a = {acc.dack_n[0], 6'h00}; // [RULE10] [RULE11]
        end else begin
            a = (mode_q == BUS_MUXED) ? lat_q : acc.addr; // [RULE1]
        end
        ch       = a[CH_SEL_BIT];
        fifo_hit = !a[FIFO_WIN_BIT];
        wide     = acc.width;
        even_hi  = moto && wide;
        if (!wide) begin
            lanes = 2'b01; // [RULE2]
        end else if (moto) begin
            lanes = {!a[0], !acc.lane_n}; // [RULE4]
        end else begin
            lanes = {!acc.lane_n, !a[0]}; // [RULE3] [RULE4]
        end
        nb  = {1'b0, lanes[0]} + {1'b0, lanes[1]};
        two = (nb == 2'h2);
        if (wr_go) begin
            ok = tx_level[ch] <= FIFO_FULL - {5'h00, nb};
        end else begin
            ok = rx_level[ch] >= {5'h00, nb};
        end
    end

    // Each active lane reaches one byte address; the even byte goes first.
    always_comb begin
        logic is_even;
        is_even   = 1'b0;
        rd_val    = WORD_RESET;
        reg_we    = 2'b00;
        tx_wdata  = WORD_RESET;
        for (int l = 0; l < 2; l++) begin
            is_even      = wide ? ((l == 1) == even_hi) : 1'b1;
            lane_addr[l] = wide ? {a[6:1], !is_even} : a;
            lane_val[l]  = acc.data[l*8 +: 8];
            if (fifo_hit) begin
                rd_val[l*8 +: 8] = !ok ? BYTE_RESET :
                                   (is_even || !two) ? rx_head[ch][7:0] : rx_head[ch][15:8];
                if (lanes[l] && (is_even || !two)) begin
                    tx_wdata[7:0] = lane_val[l];
                end else if (lanes[l]) begin
                    tx_wdata[15:8] = lane_val[l];
                end
            end else if (lane_addr[l][5:0] == STATUS_OFF) begin
                rd_val[l*8 +: 8] = {tx_level[ch] == FIFO_FULL, rx_level[ch]};
            end else if (lane_addr[l][5:0] == CMD_OFF) begin
                rd_val[l*8 +: 8] = BYTE_RESET;
            end else begin
                rd_val[l*8 +: 8] = regs_q[lane_addr[l]]; // [RULE1]
                reg_we[l]        = wr_go && lanes[l]; // [RULE1]
            end
        end
    end

    always_comb begin
        rx_pop   = 2'b00;
        tx_push  = 2'b00;
        flush_rx = 2'b00;
        flush_tx = 2'b00;
        if (rd_go && fifo_hit && ok && nb != 2'h0) begin
            rx_pop[ch] = 1'b1; // [RULE10]
        end
        if (wr_go && fifo_hit && ok && nb != 2'h0) begin
            tx_push[ch] = 1'b1; // [RULE11]
        end
        for (int l = 0; l < 2; l++) begin
            if (wr_go && lanes[l] && !fifo_hit && lane_addr[l][5:0] == CMD_OFF) begin
                flush_rx[ch] = lane_val[l][CMD_FLUSH_RX_BIT];
                flush_tx[ch] = lane_val[l][CMD_FLUSH_TX_BIT];
            end
        end
        oe_d   = rd_on ? (rd_go ? lanes : oe_q) : 2'b00;
        dout_d = rd_go ? rd_val : dout_q;
    end

    // The drivers follow the synchronised strobe, so they release one cycle after it ends.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            oe_q      <= 2'b00;
            dout_q    <= WORD_RESET;
            wide_q    <= 1'b0;
            rd_done_q <= 1'b0;
        end else begin
            oe_q      <= oe_d;
            dout_q    <= dout_d;
            wide_q    <= s2_q.width;
            rd_done_q <= rd_done_d;
        end
    end

    always_ff @(posedge clk_i) begin
        for (int l = 0; l < 2; l++) begin
            if (reg_we[l]) begin
                regs_q[lane_addr[l]] <= lane_val[l];
            end
        end
    end

    assign data_o    = dout_q;
    assign data_oe_o = {{8{oe_q[1] & wide_q}}, {8{oe_q[0]}}}; // [RULE2] [RULE3]

    for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
        logic [15:0] tx_head;
        logic        txb_two;

        assign dma_req_o[c*2+DMA_TX_IDX] = tx_level[c] != FIFO_FULL; // [RULE9]
        assign dma_req_o[c*2+DMA_RX_IDX] = rx_level[c] != LEVEL_ZERO; // [RULE9]
        assign rx_ready_o[c]             = rx_level[c] != FIFO_FULL;
        assign txb_valid[c]              = tx_level[c] != LEVEL_ZERO;
        assign txb_two                   = 1'b0;

        byte_fifo #(.DEPTH(FIFO_DEPTH), .LVL_W(LEVEL_W)) u_rx_fifo ( // [RULE8]
            .clk_i      (clk_i),
            .arst_n_i   (arst_n_i),
            .flush_i    (flush_rx[c]),
            .push_i     (rx_valid_i[c] & rx_ready_o[c] & ~flush_rx[c]),
            .push_two_i (1'b0),
            .wdata_i    ({8'h00, rx_data_i[c]}),
            .pop_i      (rx_pop[c] & ~flush_rx[c]),
            .pop_two_i  (two),
            .rdata_o    (rx_head[c]),
            .level_o    (rx_level[c])
        );

        byte_fifo #(.DEPTH(FIFO_DEPTH), .LVL_W(LEVEL_W)) u_tx_fifo ( // [RULE8]
            .clk_i      (clk_i),
            .arst_n_i   (arst_n_i),
            .flush_i    (flush_tx[c]),
            .push_i     (tx_push[c]),
            .push_two_i (two),
            .wdata_i    (tx_wdata),
            .pop_i      (txb_valid[c] & txb_ready[c] & ~flush_tx[c]),
            .pop_two_i  (txb_two),
            .rdata_o    (tx_head),
            .level_o    (tx_level[c])
        );

        // The serial side may stall; the buffer and FIFO absorb it.
        pair_buffer #(.WIDTH(8)) u_tx_buf (
            .clk_i       (clk_i),
            .arst_n_i    (arst_n_i),
            .in_valid_i  (txb_valid[c] & ~flush_tx[c]),
            .in_ready_o  (txb_ready[c]),
            .in_data_i   (tx_head[7:0]),
            .out_valid_o (tx_valid_o[c]),
            .out_ready_i (tx_ready_i[c]),
            .out_data_o  (tx_data_o[c])
        );
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    AST_ONE_TARGET: assert property ( // [RULE1]
        wr_go && !fifo_hit && a[5:1] != STATUS_OFF[5:1] && nb == 2'h1 |-> $onehot(reg_we)
    ) else $error("single byte write hit other than one register");
    AST_NARROW_UPPER_OFF: assert property ( // [RULE2]
        !s2_q.width ##1 !s2_q.width |-> data_oe_o[15:8] == 8'h00
    ) else $error("upper byte driven in narrow mode");
    AST_WIDE_WORD_READ: assert property ( // [RULE3]
        rd_go && wide && lanes == 2'b11 ##1 s2_q.width |-> data_oe_o == 16'hFFFF
    ) else $error("word read does not drive both bytes");
    AST_ONE_LANE_READ: assert property ( // [RULE4]
        rd_go && wide && nb == 2'h1 |=> $countones(oe_q) == 1
    ) else $error("byte read drives a wrong lane count");
    AST_MUX_ENTRY: assert property ( // [RULE5]
        ale_fall && rose_q |=> mode_q == BUS_MUXED
    ) else $error("toggling latch did not select multiplexed style");
    AST_ADDR_LATCH: assert property ( // [RULE6]
        mode_q == BUS_MUXED && ale_fall |=> lat_q == $past(p_q.addr)
    ) else $error("address not latched on latch fall");
    AST_FIFO_BOUND: assert property ( // [RULE8]
        rx_level[0] <= FIFO_FULL && tx_level[1] <= FIFO_FULL
    ) else $error("FIFO level beyond depth");
    AST_DMA_REQ_RX: assert property ( // [RULE9]
        rx_level[0] == LEVEL_ZERO ##1 rx_level[0] != LEVEL_ZERO |-> dma_req_o[1]
    ) else $error("receive DMA request missing");
    AST_DMA_READ_POP: assert property ( // [RULE10]
        rd_go && !s2_q.dack_n[0] && rx_level[0] >= 7'h02 |-> rx_pop[0] && !rx_pop[1]
    ) else $error("DMA read did not use the acknowledged receive FIFO");
    AST_DMA_WRITE_PUSH: assert property ( // [RULE11]
        wr_go && !p_q.dack_n[1] && p_q.dack_n[0] && tx_level[1] < 7'h3E |-> tx_push[1]
    ) else $error("DMA write did not reach the acknowledged transmit FIFO");
    AST_SELECT_NEEDED: assert property ( // [RULE12]
        s2_q.cs_n && s2_q.dack_n == 2'h3 |=> data_oe_o == 16'h0000
    ) else $error("bus driven without select");
endmodule : host_port
`default_nettype wire

// File: tb/serial_far_end.sv
// Far-end model of the serial side: supplies receive bytes, takes transmit bytes.
`timescale 1ns/1ps
`default_nettype none
module serial_far_end (
    // Clock and reset
    input  wire logic            clk_i,
    input  wire logic            arst_n_i,
    // Receive bytes towards the port
    output logic      [1:0]      rx_valid_o,
    output logic      [1:0][7:0] rx_data_o,
    input  wire logic [1:0]      rx_ready_i,
    // Transmit bytes from the port
    input  wire logic [1:0]      tx_valid_i,
    input  wire logic [1:0][7:0] tx_data_i,
    output logic      [1:0]      tx_ready_o
);
    logic       stall_q;
    logic [8:0] seen_q[$];
    initial begin
        rx_valid_o = 2'h0;
        rx_data_o  = 16'hA55A;
    end
    // Stalling every other cycle makes the transmit buffer hold bytes.
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stall_q <= 1'b0;
        end else begin
            stall_q <= ~stall_q;
        end
    end
    assign tx_ready_o = {2{~stall_q}};
    always @(posedge clk_i) begin
        for (int c = 0; c < 2; c++) begin
            if (arst_n_i && tx_valid_i[c] && tx_ready_o[c]) begin
                seen_q.push_back({c[0], tx_data_i[c]});
            end
        end
    end
    // Offers one byte and holds it until taken or four cycles pass; ready is read settled, after the edge.
    task automatic send(input int c, input logic [7:0] b, output bit ok);
        ok = 1'b0;
        @(posedge clk_i);
        rx_valid_o[c] <= 1'b1;
        rx_data_o[c]  <= b;
        for (int i = 0; i < 4 && !ok; i++) begin
            #1 ok = rx_ready_i[c];
            @(posedge clk_i);
        end
        rx_valid_o[c] <= 1'b0;
        rx_data_o[c]  <= ~b;
    endtask : send
endmodule : serial_far_end
`default_nettype wire

// File: tb/tb_host_port.sv
// Self-checking bench of the host bus port.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin \
    n_checks++; \
    if ((gt) !== (ex)) begin \
        fail_count++; \
        $display("wrong value %s expected %h seen %h", nm, ex, gt); \
    end \
end
module tb_host_port;
    import hostport_pkg::*;
    logic            clk_i = 1'b0;
    logic            arst_n_i = 1'b0;
    pins_t           pins_q = PINS_IDLE;
    logic [15:0]     data_o, data_oe_o, d, oe;
    logic [3:0]      dma_req_o;
    logic [1:0]      rx_valid, rx_ready, tx_valid, tx_ready;
    logic [1:0][7:0] rx_data, tx_data;
    bit              ok;
    int              fail_count = 0;
    int              n_checks = 0;
    always #2.5 clk_i = ~clk_i;
    host_port dut_u (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(pins_q.addr), .ale_i(pins_q.ale),
        .read_or_data_strobe_n_i(pins_q.read_or_data_strobe_n), .write_or_rw_n_i(pins_q.wr_rw_n),
        .cs_n_i(pins_q.cs_n), .width_i(pins_q.width), .byte_lane_select_n_i(pins_q.lane_n),
        .dma_ack_channel_one_n_i(pins_q.dack_n[0]), .dma_ack_channel_two_n_i(pins_q.dack_n[1]),
        .data_i(pins_q.data), .data_o(data_o), .data_oe_o(data_oe_o), .dma_req_o(dma_req_o),
        .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_ready_o(rx_ready),
        .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_ready_i(tx_ready));
    serial_far_end far_u (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
        .rx_ready_i(rx_ready), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
        .tx_ready_o(tx_ready));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc
    // Strobes outlast the two-flop synchronisers with margin; data stays past the end.
    task automatic wr(input logic [6:0] a, input logic [15:0] v);
        @(posedge clk_i);
        pins_q.addr    <= a;
        pins_q.data    <= v;
        pins_q.wr_rw_n <= 1'b0;
        cyc(8);
        pins_q.wr_rw_n <= 1'b1;
        cyc(6);
    endtask : wr
    task automatic rd(input logic [6:0] a);
        @(posedge clk_i);
        pins_q.addr    <= a;
        pins_q.read_or_data_strobe_n <= 1'b0;
        cyc(8);
        d = data_o;
        oe = data_oe_o;
        pins_q.read_or_data_strobe_n <= 1'b1;
        cyc(6);
    endtask : rd
    task automatic strobe_acc(input logic [6:0] a, input logic [15:0] v, input logic r);
        @(posedge clk_i);
        pins_q.addr    <= a;
        pins_q.data    <= v;
        pins_q.wr_rw_n <= r;
        pins_q.read_or_data_strobe_n <= 1'b0;
        cyc(8);
        d = data_o;
        oe = data_oe_o;
        pins_q.read_or_data_strobe_n <= 1'b1;
        cyc(6);
    endtask : strobe_acc
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict
    task automatic t_reset();
        `CHK("reset oe", 16'h0000, data_oe_o)
        `CHK("reset dma", 4'h5, dma_req_o)
        `CHK("reset rx ready", 2'h3, rx_ready)
    endtask : t_reset
    task automatic t_narrow();
        pins_q.cs_n <= 1'b0;
        wr(7'h22, 16'h005A);
        wr(7'h23, 16'hFFA5);
        rd(7'h22);
        `CHK("byte 22", 8'h5A, d[7:0])
        `CHK("narrow oe", 16'h00FF, oe)
        rd(7'h23);
        `CHK("byte 23", 8'hA5, d[7:0])
        rd(7'h20);
        `CHK("idle status", 8'h00, d[7:0])
    endtask : t_narrow
    task automatic t_select();
        pins_q.cs_n <= 1'b1;
        wr(7'h22, 16'h0011);
        rd(7'h22);
        `CHK("unselected oe", 16'h0000, oe)
        pins_q.cs_n <= 1'b0;
        rd(7'h22);
        `CHK("unselected write", 8'h5A, d[7:0])
    endtask : t_select
    task automatic t_wide();
        pins_q.width  <= 1'b1;
        pins_q.lane_n <= 1'b0;
        wr(7'h24, 16'hBEEF);
        rd(7'h24);
        `CHK("word", 32'hBEEFFFFF, {d, oe})
        rd(7'h25);
        `CHK("high lane", 24'hBEFF00, {d[15:8], oe})
        pins_q.lane_n <= 1'b1;
        rd(7'h24);
        `CHK("low lane", 24'hEF00FF, {d[7:0], oe})
        pins_q.width <= 1'b0;
        rd(7'h25);
        `CHK("narrow odd", 24'hBE00FF, {d[7:0], oe})
    endtask : t_wide
    task automatic t_dma();
        pins_q.cs_n   <= 1'b1;
        pins_q.dack_n <= 2'h2;
        wr(7'h7F, 16'h0033);
        for (int i = 0; i < 60 && far_u.seen_q.size() == 0; i++) begin
            cyc(1);
        end
        if (far_u.seen_q.size() == 0) begin
            fail_count++;
            give_verdict();
        end
        `CHK("dma tx byte", 9'h033, far_u.seen_q[0])
        far_u.send(0, 8'h77, ok);
        `CHK("dma rx offer", 1'b1, ok)
        cyc(4);
        `CHK("rx request", 1'b1, dma_req_o[1])
        rd(7'h7F);
        `CHK("dma rx byte", 8'h77, d[7:0])
        `CHK("rx drained", 1'b0, dma_req_o[1])
        pins_q.dack_n <= 2'h3;
        pins_q.cs_n   <= 1'b0;
        far_u.send(0, 8'h55, ok);
        wr(7'h21, 16'h0001);
        `CHK("flushed rx", 2'h2, {ok, dma_req_o[1]})
    endtask : t_dma
    // Fills the second receive FIFO until it refuses, then drains it in order.
    task automatic t_fill();
        for (int i = 0; i < 64; i++) begin
            far_u.send(1, 8'(i + 16), ok);
            `CHK("fill accept", 1'b1, ok)
        end
        far_u.send(1, 8'hEE, ok);
        `CHK("full refuse", 3'h0, {ok, rx_ready[1], dma_req_o[3] ^ 1'b1})
        rd(7'h60);
        `CHK("full status", 8'h40, d[7:0])
        for (int i = 0; i < 64; i++) begin
            rd(7'h40);
            `CHK("fifo order", 8'(i + 16), d[7:0])
        end
        rd(7'h60);
        `CHK("empty status", 9'h000, {d[7:0], dma_req_o[3]})
    endtask : t_fill
    // A latch pin held high selects the data-strobe style, where the lanes swap roles.
    task automatic t_ds();
        pins_q.ale    <= 1'b1;
        pins_q.width  <= 1'b1;
        pins_q.lane_n <= 1'b0;
        strobe_acc(7'h26, 16'hC3D2, 1'b0);
        strobe_acc(7'h26, 16'h0000, 1'b1);
        `CHK("strobe word", 32'hC3D2FFFF, {d, oe})
        strobe_acc(7'h27, 16'h0000, 1'b1);
        `CHK("strobe low lane", 24'hD200FF, {d[7:0], oe})
        pins_q.lane_n <= 1'b1;
        strobe_acc(7'h26, 16'h0000, 1'b1);
        `CHK("strobe high lane", 24'hC3FF00, {d[15:8], oe})
        pins_q.width <= 1'b0;
    endtask : t_ds
    // Address pins follow the low data lines, so only the latched value may count.
    task automatic t_mux();
        @(posedge clk_i);
        pins_q.addr <= 7'h22;
        pins_q.data <= 16'h0022;
        pins_q.ale  <= 1'b1;
        cyc(4);
        pins_q.ale <= 1'b0;
        cyc(4);
        pins_q.data <= 16'h0001;
        rd(7'h01);
        `CHK("latched address", 8'h5A, d[7:0])
        `CHK("muxed oe", 16'h00FF, oe)
    endtask : t_mux
    initial begin
        cyc(6);
        t_reset();
        arst_n_i <= 1'b1;
        cyc(6);
        t_narrow();
        t_select();
        t_wide();
        t_dma();
        t_fill();
        t_ds();
        t_mux();
        give_verdict();
    end
endmodule : tb_host_port
`default_nettype wire
